// file: rtl/brcs_defines.vh
`ifndef BRCS_DEFINES_VH
`define BRCS_DEFINES_VH

// ----------------------------------------------------------------
// reference clock and oversampling
// ----------------------------------------------------------------
// rates come out standard only at this reference frequency
`define BRCS_REF_HZ         3686400
`define BRCS_OVERSAMPLE     16
`define BRCS_SYS_PERIOD_NS  10

// ----------------------------------------------------------------
// rate generator sizing
// ----------------------------------------------------------------
`define BRCS_NUM_RATES      23
`define BRCS_SET_SIZE       13
`define BRCS_DIV_W          13
`define BRCS_IDX_W          5
`define BRCS_NUM_PINS       4

// ----------------------------------------------------------------
// clock selector layout and codes
// ----------------------------------------------------------------
`define BRCS_SEL_RX_MSB     7
`define BRCS_SEL_RX_LSB     4
`define BRCS_SEL_TX_MSB     3
`define BRCS_SEL_TX_LSB     0
`define BRCS_CODE_CT        4'hD
`define BRCS_CODE_EXT16     4'hE
`define BRCS_CODE_EXT1      4'hF

`endif

// file: rtl/brcs_chan_clock_mux.v
`timescale 1ns/1ps
`include "brcs_defines.vh"

module brcs_chan_clock_mux #(
    parameter TX_PIN = 0,
    parameter RX_PIN = 1
) (
    input  wire                      i_clk_sys,
    input  wire                      i_reset,
    input  wire [7:0]                i_clock_selector,
    input  wire [`BRCS_SET_SIZE-1:0] i_set_tick,
    input  wire                      i_ct_tick,
    input  wire [`BRCS_NUM_PINS-1:0] i_pin_tick,
    output wire                      o_tx_clk_en,
    output wire                      o_tx_is_1x,
    output wire                      o_rx_clk_en,
    output wire                      o_rx_is_1x
);

    // ----------------------------------------------------------------
    // one direction: 4-bit code picks a source
    // ----------------------------------------------------------------
    function pick_tick;
        input [3:0]                code;
        input [`BRCS_SET_SIZE-1:0] set_tick;
        input                      ct_tick;
        input                      pin_tick;
        begin
            if (code == `BRCS_CODE_CT) begin
                pick_tick = ct_tick;
            end else if (code == `BRCS_CODE_EXT16 || code == `BRCS_CODE_EXT1) begin
                pick_tick = pin_tick;
            end else begin
                pick_tick = set_tick[code];
            end
        end
    endfunction

    wire [3:0] tx_code = i_clock_selector[`BRCS_SEL_TX_MSB:`BRCS_SEL_TX_LSB];
    wire [3:0] rx_code = i_clock_selector[`BRCS_SEL_RX_MSB:`BRCS_SEL_RX_LSB];

    reg tx_en_ff;
    reg tx_1x_ff;
    reg rx_en_ff;
    reg rx_1x_ff;

    // selection is purely combinational into a flop, so a new code only
    // changes which pulses pass; nothing upstream is restarted
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            tx_en_ff <= 1'b0;
            tx_1x_ff <= 1'b0;
            rx_en_ff <= 1'b0;
            rx_1x_ff <= 1'b0;
        end else begin
            tx_en_ff <= pick_tick(tx_code, i_set_tick, i_ct_tick, i_pin_tick[TX_PIN]);
            rx_en_ff <= pick_tick(rx_code, i_set_tick, i_ct_tick, i_pin_tick[RX_PIN]);
            tx_1x_ff <= (tx_code == `BRCS_CODE_EXT1);
            rx_1x_ff <= (rx_code == `BRCS_CODE_EXT1);
        end
    end

    assign o_tx_clk_en = tx_en_ff;
    assign o_tx_is_1x  = tx_1x_ff;
    assign o_rx_clk_en = rx_en_ff;
    assign o_rx_is_1x  = rx_1x_ff;

endmodule

// file: rtl/brcs_rate_clock_select.v
`timescale 1ns/1ps
`include "brcs_defines.vh"

module brcs_rate_clock_select (
    input  wire                      i_clk_sys,
    input  wire                      i_reset,
    input  wire                      i_ref_clock_in,
    input  wire [`BRCS_NUM_PINS-1:0] i_ext_clock_pin,
    input  wire                      i_aux_control_rate_set,
    input  wire [7:0]                i_chan_a_clock_selector,
    input  wire [7:0]                i_chan_b_clock_selector,
    input  wire                      i_ct_square,
    output wire                      o_ref_tick,
    output wire                      o_chan_a_tx_clk_en,
    output wire                      o_chan_a_tx_is_1x,
    output wire                      o_chan_a_rx_clk_en,
    output wire                      o_chan_a_rx_is_1x,
    output wire                      o_chan_b_tx_clk_en,
    output wire                      o_chan_b_tx_is_1x,
    output wire                      o_chan_b_rx_clk_en,
    output wire                      o_chan_b_rx_is_1x
);

    // ----------------------------------------------------------------
    // standard rates, in tenths of a bit per second
    // ----------------------------------------------------------------
    // tenths keep 134.5 bps exact in integer arithmetic
    function integer rate_tenths;
        input integer idx;
        begin
            case (idx)
                0:       rate_tenths = 500;
                1:       rate_tenths = 750;
                2:       rate_tenths = 1100;
                3:       rate_tenths = 1345;
                4:       rate_tenths = 1500;
                5:       rate_tenths = 2000;
                6:       rate_tenths = 3000;
                7:       rate_tenths = 6000;
                8:       rate_tenths = 10500;
                9:       rate_tenths = 12000;
                10:      rate_tenths = 18000;
                11:      rate_tenths = 20000;
                12:      rate_tenths = 24000;
                13:      rate_tenths = 36000;
                14:      rate_tenths = 48000;
                15:      rate_tenths = 72000;
                16:      rate_tenths = 96000;
                17:      rate_tenths = 144000;
                18:      rate_tenths = 192000;
                19:      rate_tenths = 288000;
                20:      rate_tenths = 384000;
                21:      rate_tenths = 576000;
                default: rate_tenths = 1152000;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // rate sets: selector code to rate index
    // ----------------------------------------------------------------
    function [`BRCS_IDX_W-1:0] set_index;
        input       set_sel;
        input [3:0] code;
        begin
            case ({set_sel, code})
                5'h00:   set_index = 5'h00;
                5'h01:   set_index = 5'h02;
                5'h02:   set_index = 5'h03;
                5'h03:   set_index = 5'h05;
                5'h04:   set_index = 5'h06;
                5'h05:   set_index = 5'h07;
                5'h06:   set_index = 5'h09;
                5'h07:   set_index = 5'h08;
                5'h08:   set_index = 5'h0C;
                5'h09:   set_index = 5'h0E;
                5'h0A:   set_index = 5'h0F;
                5'h0B:   set_index = 5'h10;
                5'h0C:   set_index = 5'h14;
                5'h10:   set_index = 5'h01;
                5'h11:   set_index = 5'h0D;
                5'h12:   set_index = 5'h11;
                5'h13:   set_index = 5'h04;
                5'h14:   set_index = 5'h13;
                5'h15:   set_index = 5'h15;
                5'h16:   set_index = 5'h09;
                5'h17:   set_index = 5'h0B;
                5'h18:   set_index = 5'h16;
                5'h19:   set_index = 5'h0E;
                5'h1A:   set_index = 5'h0A;
                5'h1B:   set_index = 5'h10;
                5'h1C:   set_index = 5'h12;
                default: set_index = 5'h00;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------------------------------
    // the reference and the pins are sampled, not used as clocks; the
    // system clock must be well above twice the fastest pin frequency
    reg                      ref_s1_ff;
    reg                      ref_s2_ff;
    reg                      ref_s3_ff;
    reg                      ref_tick_ff;
    reg [`BRCS_NUM_PINS-1:0] pin_s1_ff;
    reg [`BRCS_NUM_PINS-1:0] pin_s2_ff;
    reg [`BRCS_NUM_PINS-1:0] pin_s3_ff;
    reg [`BRCS_NUM_PINS-1:0] pin_tick_ff;
    reg                      ct_prev_ff;
    reg                      ct_tick_ff;

    wire ref_edge = ref_s2_ff & ~ref_s3_ff;

    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ref_s1_ff   <= 1'b0;
            ref_s2_ff   <= 1'b0;
            ref_s3_ff   <= 1'b0;
            ref_tick_ff <= 1'b0;
            pin_s1_ff   <= {`BRCS_NUM_PINS{1'b0}};
            pin_s2_ff   <= {`BRCS_NUM_PINS{1'b0}};
            pin_s3_ff   <= {`BRCS_NUM_PINS{1'b0}};
            pin_tick_ff <= {`BRCS_NUM_PINS{1'b0}};
            ct_prev_ff  <= 1'b0;
            ct_tick_ff  <= 1'b0;
        end else begin
            ref_s1_ff   <= i_ref_clock_in;
            ref_s2_ff   <= ref_s1_ff;
            ref_s3_ff   <= ref_s2_ff;
            ref_tick_ff <= ref_edge;
            pin_s1_ff   <= i_ext_clock_pin;
            pin_s2_ff   <= pin_s1_ff;
            pin_s3_ff   <= pin_s2_ff;
            pin_tick_ff <= pin_s2_ff & ~pin_s3_ff;
            ct_prev_ff  <= i_ct_square;
            ct_tick_ff  <= i_ct_square & ~ct_prev_ff;
        end
    end

    assign o_ref_tick = ref_tick_ff;

    // ----------------------------------------------------------------
    // rate generator: one free-running divider per rate
    // ----------------------------------------------------------------
    wire [`BRCS_NUM_RATES-1:0] rate_tick;

    genvar gi;
    generate
        for (gi = 0; gi < `BRCS_NUM_RATES; gi = gi + 1) begin : g_rate
            // rounded reference / (16 * rate); counts reference edges
            localparam integer DIV = (`BRCS_REF_HZ * 10 + `BRCS_OVERSAMPLE * rate_tenths(gi) / 2)
                                     / (`BRCS_OVERSAMPLE * rate_tenths(gi));
            localparam [31:0]            DIV_M1   = DIV - 1;
            localparam [`BRCS_DIV_W-1:0] DIV_LAST = DIV_M1[`BRCS_DIV_W-1:0];
            reg [`BRCS_DIV_W-1:0] cnt_ff;
            reg                   tick_ff;
            always @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    cnt_ff  <= {`BRCS_DIV_W{1'b0}};
                    tick_ff <= 1'b0;
                end else begin
                    tick_ff <= ref_edge && (cnt_ff == DIV_LAST);
                    if (ref_edge) begin
                        if (cnt_ff == DIV_LAST) begin
                            cnt_ff <= {`BRCS_DIV_W{1'b0}};
                        end else begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end
                end
            end
            // each divider owns its flop, so every bit has a single driver
            assign rate_tick[gi] = tick_ff;
        end
    endgenerate

    // ----------------------------------------------------------------
    // rate set selection
    // ----------------------------------------------------------------
    wire [`BRCS_SET_SIZE-1:0] set_tick;

    generate
        for (gi = 0; gi < `BRCS_SET_SIZE; gi = gi + 1) begin : g_set
            localparam [31:0] CODE = gi;
            assign set_tick[gi] = rate_tick[set_index(i_aux_control_rate_set, CODE[3:0])];
        end
    endgenerate

    // ----------------------------------------------------------------
    // per-channel clock selectors
    // ----------------------------------------------------------------
    // pins 0..3: a tx, a rx, b tx, b rx
    brcs_chan_clock_mux #(
        .TX_PIN (0),
        .RX_PIN (1)
    ) u_chan_a (
        .i_clk_sys        (i_clk_sys),
        .i_reset          (i_reset),
        .i_clock_selector (i_chan_a_clock_selector),
        .i_set_tick       (set_tick),
        .i_ct_tick        (ct_tick_ff),
        .i_pin_tick       (pin_tick_ff),
        .o_tx_clk_en      (o_chan_a_tx_clk_en),
        .o_tx_is_1x       (o_chan_a_tx_is_1x),
        .o_rx_clk_en      (o_chan_a_rx_clk_en),
        .o_rx_is_1x       (o_chan_a_rx_is_1x)
    );

    brcs_chan_clock_mux #(
        .TX_PIN (2),
        .RX_PIN (3)
    ) u_chan_b (
        .i_clk_sys        (i_clk_sys),
        .i_reset          (i_reset),
        .i_clock_selector (i_chan_b_clock_selector),
        .i_set_tick       (set_tick),
        .i_ct_tick        (ct_tick_ff),
        .i_pin_tick       (pin_tick_ff),
        .o_tx_clk_en      (o_chan_b_tx_clk_en),
        .o_tx_is_1x       (o_chan_b_tx_is_1x),
        .o_rx_clk_en      (o_chan_b_rx_clk_en),
        .o_rx_is_1x       (o_chan_b_rx_is_1x)
    );

endmodule

// file: testbench/brcs_rate_clock_select_properties.sv
`timescale 1ns/1ps
`include "brcs_defines.vh"

// ----------------------------------------------------------------
// source to enable latency, 1x flag and pulse width checks
// ----------------------------------------------------------------
module brcs_props (
    input wire                      i_clk_sys,
    input wire                      i_reset,
    input wire                      i_ref_clock_in,
    input wire [`BRCS_NUM_PINS-1:0] i_ext_clock_pin,
    input wire                      i_aux_control_rate_set,
    input wire [7:0]                i_chan_a_clock_selector,
    input wire [7:0]                i_chan_b_clock_selector,
    input wire                      i_ct_square,
    input wire                      o_ref_tick,
    input wire                      o_chan_a_tx_clk_en,
    input wire                      o_chan_a_tx_is_1x,
    input wire                      o_chan_a_rx_clk_en,
    input wire                      o_chan_a_rx_is_1x,
    input wire                      o_chan_b_tx_clk_en,
    input wire                      o_chan_b_tx_is_1x,
    input wire                      o_chan_b_rx_clk_en,
    input wire                      o_chan_b_rx_is_1x
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // latencies hold only while the selector code is left alone
    AST_REF_PULSE: assert property (o_ref_tick |=> !o_ref_tick)
        else $error("ref tick wider than one cycle");
    AST_REF_LAT: assert property ($rose(i_ref_clock_in) |-> ##3 o_ref_tick)
        else $error("ref tick late or missing");
    AST_A_TX_1X: assert property (!$past(i_reset) |->
        o_chan_a_tx_is_1x == ($past(i_chan_a_clock_selector[3:0]) == 4'hF))
        else $error("a tx 1x flag wrong");
    AST_B_RX_1X: assert property (!$past(i_reset) |->
        o_chan_b_rx_is_1x == ($past(i_chan_b_clock_selector[7:4]) == 4'hF))
        else $error("b rx 1x flag wrong");
    AST_A_TX_PIN: assert property ($rose(i_ext_clock_pin[0]) &&
        i_chan_a_clock_selector[3:0] == 4'hE |-> ##4 o_chan_a_tx_clk_en)
        else $error("a tx pin edge lost");
    AST_A_RX_PIN: assert property ($rose(i_ext_clock_pin[1]) &&
        i_chan_a_clock_selector[7:4] == 4'hF |-> ##4 o_chan_a_rx_clk_en)
        else $error("a rx pin edge lost");
    AST_B_TX_PIN: assert property ($rose(i_ext_clock_pin[2]) &&
        i_chan_b_clock_selector[3:0] == 4'hE |-> ##4 o_chan_b_tx_clk_en)
        else $error("b tx pin edge lost");
    AST_B_RX_CT: assert property ($rose(i_ct_square) &&
        i_chan_b_clock_selector[7:4] == 4'hD |-> ##2 o_chan_b_rx_clk_en)
        else $error("b rx timer edge lost");
    AST_A_RX_PULSE: assert property (o_chan_a_rx_clk_en |=> !o_chan_a_rx_clk_en)
        else $error("a rx enable wider than one cycle");
endmodule

bind brcs_rate_clock_select brcs_props u_props (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ref_clock_in(i_ref_clock_in),
    .i_ext_clock_pin(i_ext_clock_pin), .i_aux_control_rate_set(i_aux_control_rate_set),
    .i_chan_a_clock_selector(i_chan_a_clock_selector), .i_ct_square(i_ct_square),
    .i_chan_b_clock_selector(i_chan_b_clock_selector), .o_ref_tick(o_ref_tick),
    .o_chan_a_tx_clk_en(o_chan_a_tx_clk_en), .o_chan_a_tx_is_1x(o_chan_a_tx_is_1x),
    .o_chan_a_rx_clk_en(o_chan_a_rx_clk_en), .o_chan_a_rx_is_1x(o_chan_a_rx_is_1x),
    .o_chan_b_tx_clk_en(o_chan_b_tx_clk_en), .o_chan_b_tx_is_1x(o_chan_b_tx_is_1x),
    .o_chan_b_rx_clk_en(o_chan_b_rx_clk_en), .o_chan_b_rx_is_1x(o_chan_b_rx_is_1x));

// file: testbench/brcs_rate_clock_select_bench.sv
`timescale 1ns/1ps
`include "brcs_defines.vh"
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin bad_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module brcs_rate_clock_select_bench;
    reg       clk = 0, rst = 1, refc = 0, rset = 0, ct = 0, ph = 0;
    reg [3:0] pin = 0, m;
    reg [7:0] sa = 0, sb = 0;
    wire      tick, atx, a1x, arx, ar1x, btx, b1x, brx, br1x;
    wire [4:0] en = {tick, brx, btx, arx, atx};
    int bad_count = 0, checks_done = 0, cnt[5] = '{default: 0}, c0[5];
    int per, i, k, s, c, d, n;
    int idx0[13] = '{0, 2, 3, 5, 6, 7, 9, 8, 12, 14, 15, 16, 20};
    int idx1[13] = '{1, 13, 17, 4, 19, 21, 9, 11, 22, 14, 10, 16, 18};
    int divt[23] = '{4608, 3072, 2095, 1713, 1536, 1152, 768, 384, 219, 192, 128, 115,
                     96, 64, 48, 32, 24, 16, 12, 8, 6, 4, 2};

    brcs_rate_clock_select dut (
        .i_clk_sys(clk), .i_reset(rst), .i_ref_clock_in(refc), .i_ext_clock_pin(pin),
        .i_aux_control_rate_set(rset), .i_chan_a_clock_selector(sa),
        .i_chan_b_clock_selector(sb), .i_ct_square(ct), .o_ref_tick(tick),
        .o_chan_a_tx_clk_en(atx), .o_chan_a_tx_is_1x(a1x), .o_chan_a_rx_clk_en(arx),
        .o_chan_a_rx_is_1x(ar1x), .o_chan_b_tx_clk_en(btx), .o_chan_b_tx_is_1x(b1x),
        .o_chan_b_rx_clk_en(brx), .o_chan_b_rx_is_1x(br1x));

    // ------------------------------------------------------------
    // clocks and edge counters
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    // reference at four system cycles keeps the divided rates that pk picks short to measure
    always @(negedge clk) begin
        ph <= ~ph;
        if (ph) refc <= ~refc;
    end
    always @(posedge clk) begin
        for (int j = 0; j < 5; j++) if (en[j] === 1'b1) cnt[j] <= cnt[j] + 1;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function int dv(input int fs, input int fc);
        return divt[fs ? idx1[fc] : idx0[fc]] * 4;
    endfunction
    function int pk(input int fs);
        int r;
        do r = $urandom % 13; while (dv(fs, r) > 192);
        return r;
    endfunction
    // period between two enables; a stale first pulse is never counted
    task measure(input int w, output int p);
        int b, t;
        b = cnt[w];
        t = 0;
        p = 0;
        while (cnt[w] < b + 1 && t < 2000) begin
            @(posedge clk);
            #1;
            t++;
        end
        while (cnt[w] < b + 2 && t < 2000) begin
            @(posedge clk);
            #1;
            t++;
            p++;
        end
        // a missing pulse counts against the run even if the period looks right
        if (t >= 2000) bad_count++;
    endtask
    task pulse(input [3:0] pm, input pc, input int pn);
        repeat (pn) begin
            @(negedge clk);
            pin = pm;
            ct = pc;
            repeat (3) @(negedge clk);
            pin = 0;
            ct = 0;
            repeat (3) @(negedge clk);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        // about three times the longest expected run
        #(`BRCS_SYS_PERIOD_NS * 50000);
        bad_count++;
        stop_test;
    end

    initial begin
        s = $urandom(91);
        repeat (5) @(negedge clk);
        rst = 0;
        measure(4, per);
        `CHK("ref period", 4, per);
        for (i = 0; i < 10; i++) begin
            s = (i == 0) ? 1 : $urandom % 2;
            c = (i == 0) ? 8 : pk(s);
            d = pk(s);
            @(negedge clk);
            rset = s[0];
            sa = {d[3:0], c[3:0]};
            sb = {c[3:0], d[3:0]};
            repeat (4) @(negedge clk);
            measure(0, per);
            `CHK("a tx period", dv(s, c), per);
            measure(1, per);
            `CHK("a rx period", dv(s, d), per);
            measure(2, per);
            `CHK("b tx period", dv(s, d), per);
            measure(3, per);
            `CHK("b rx period", dv(s, c), per);
        end
        for (i = 0; i < 16; i++) begin
            @(negedge clk);
            sa = {4'($urandom), 4'(i)};
            sb = {4'(i), 4'($urandom)};
            @(negedge clk);
            `CHK("a tx 1x", i == 15, a1x);
            `CHK("b rx 1x", i == 15, br1x);
            `CHK("a rx 1x", sa[7:4] == 4'hF, ar1x);
            `CHK("b tx 1x", sb[3:0] == 4'hF, b1x);
        end
        sa = 8'hFE;
        sb = 8'hFE;
        for (i = 0; i < 5; i++) begin
            m = (i == 0) ? 4'hF : 4'($urandom % 15 + 1);
            if (i == 4) begin
                sa = 8'hDD;
                sb = 8'hDD;
                m = 0;
            end
            n = 1 + $urandom % 4;
            repeat (4) @(negedge clk);
            c0 = cnt;
            pulse(m, i == 4, n);
            repeat (8) @(negedge clk);
            for (k = 0; k < 4; k++)
                `CHK("edges", (m[k] || i == 4) ? n : 0, cnt[k] - c0[k]);
        end
        stop_test;
    end
endmodule
